// *** bench/config_control_properties.sv ***
// port assertions for the configuration control block
`timescale 1ns/1ns
module config_control_properties #(
   parameter int unsigned TRACE_HALF = 1
) (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic [7:0]  avsAddress,
   input wire logic        avsRead,
   input wire logic        avsWrite,
   input wire logic [31:0] avsWritedata,
   input wire logic [3:0]  avsByteenable,
   input wire logic [31:0] avsReaddata,
   input wire logic        avsWaitrequest,
   input wire logic        chargePumpEn,
   input wire logic        eccEnable,
   input wire logic        dynEccEnable,
   input wire logic        wordProgBlock,
   input wire logic        debugPortEn,
   input wire logic        traceOutEn,
   input wire logic        traceClk,
   input wire logic        twoWireUseTdo
);
   localparam int HALF = TRACE_HALF;
   logic       wrCfg;
   logic       rdCfg;
   logic [3:0] fld;
   assign wrCfg = avsWrite && !avsWaitrequest && avsByteenable[0]
      && avsAddress == cfg_ctrl_pkg::OFS_CONFIG;
   assign rdCfg = avsRead && !avsWaitrequest
      && avsAddress == cfg_ctrl_pkg::OFS_CONFIG;
   assign fld = {avsWritedata[7], avsWritedata[3:2], avsWritedata[0]};
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   property p_wait_one; !avsWaitrequest |=> avsWaitrequest; endproperty
   a_wait_one: assert property (p_wait_one)
      else $error("accept cycle too long");
   property p_answer;
      (avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest;
   endproperty
   a_answer: assert property (p_answer)
      else $error("request not answered in one cycle");
   property p_wr_cfg;
      wrCfg |=> {chargePumpEn, debugPortEn, traceOutEn, twoWireUseTdo}
         == $past(fld);
   endproperty
   a_wr_cfg: assert property (p_wr_cfg)
      else $error("field outputs differ from write");
   property p_rd_cfg;
      rdCfg |-> avsReaddata == {24'h0, chargePumpEn, 1'b0, avsReaddata[5:4],
         debugPortEn, traceOutEn, 1'b0, twoWireUseTdo};
   endproperty
   a_rd_cfg: assert property (p_rd_cfg)
      else $error("config read mismatch");
   property p_excl; !(eccEnable && dynEccEnable); endproperty
   a_excl: assert property (p_excl)
      else $error("both correction modes on");
   property p_block; wordProgBlock == eccEnable; endproperty
   a_block: assert property (p_block)
      else $error("word block differs from correction on");
   property p_lock;
      eccEnable || dynEccEnable |=> $stable({eccEnable, dynEccEnable});
   endproperty
   a_lock: assert property (p_lock)
      else $error("locked mode changed");
   property p_trace_off; !traceOutEn [*4] |-> !traceClk; endproperty
   a_trace_off: assert property (p_trace_off)
      else $error("trace clock runs while disabled");
   property p_trace_on;
      traceOutEn [*4] |-> ##[1:HALF] $changed(traceClk);
   endproperty
   a_trace_on: assert property (p_trace_on)
      else $error("trace clock stuck while enabled");
   c_wr: cover property (wrCfg);
   c_lock: cover property (eccEnable);
   c_trace: cover property (traceOutEn [*4]);
endmodule

bind config_control config_control_properties #(.TRACE_HALF(TRACE_HALF))
   u_props (
      .clk            (clk),
      .resetn         (resetn),
      .avsAddress     (avsAddress),
      .avsRead        (avsRead),
      .avsWrite       (avsWrite),
      .avsWritedata   (avsWritedata),
      .avsByteenable  (avsByteenable),
      .avsReaddata    (avsReaddata),
      .avsWaitrequest (avsWaitrequest),
      .chargePumpEn   (chargePumpEn),
      .eccEnable      (eccEnable),
      .dynEccEnable   (dynEccEnable),
      .wordProgBlock  (wordProgBlock),
      .debugPortEn    (debugPortEn),
      .traceOutEn     (traceOutEn),
      .traceClk       (traceClk),
      .twoWireUseTdo  (twoWireUseTdo)
   );

// *** bench/config_control_tb.sv ***
// self-checking bench for the configuration control block
`timescale 1ns/1ns
module config_control_tb;
   logic        clk;
   logic        resetn;
   logic [7:0]  avsAddress;
   logic        avsRead;
   logic        avsWrite;
   logic [31:0] avsWritedata;
   logic [3:0]  avsByteenable;
   logic [31:0] avsReaddata;
   logic        avsWaitrequest;
   logic        chargePumpEn;
   logic        eccEnable;
   logic        dynEccEnable;
   logic        wordProgBlock;
   logic        debugPortEn;
   logic        traceOutEn;
   logic        traceClk;
   logic        twoWireUseTdo;
   logic [31:0] outs;
   logic [31:0] q;
   int          n_fail;
   int          checks;
   int          i;
   assign outs = {25'h0, chargePumpEn, debugPortEn, traceOutEn,
      twoWireUseTdo, eccEnable, dynEccEnable, wordProgBlock};
   config_control #(.TRACE_HALF(1)) u_dut (
      .clk            (clk),
      .resetn         (resetn),
      .avsAddress     (avsAddress),
      .avsRead        (avsRead),
      .avsWrite       (avsWrite),
      .avsWritedata   (avsWritedata),
      .avsByteenable  (avsByteenable),
      .avsReaddata    (avsReaddata),
      .avsWaitrequest (avsWaitrequest),
      .chargePumpEn   (chargePumpEn),
      .eccEnable      (eccEnable),
      .dynEccEnable   (dynEccEnable),
      .wordProgBlock  (wordProgBlock),
      .debugPortEn    (debugPortEn),
      .traceOutEn     (traceOutEn),
      .traceClk       (traceClk),
      .twoWireUseTdo  (twoWireUseTdo)
   );
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic test_done;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
      input string what);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: %s %h not %h", $time, what, seen, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] be);
      int k;
      @(posedge clk);
      avsAddress <= a;
      avsWrite <= wr;
      avsRead <= !wr;
      avsWritedata <= d;
      avsByteenable <= be;
      for (k = 0; k < 20; k++) begin
         @(posedge clk);
         if (avsWaitrequest === 1'b0) begin
            break;
         end
      end
      if (k == 20) begin
         n_fail++;
         $display("unexpected at %0t: bus answer timed out", $time);
         test_done();
      end
      q = avsReaddata;
      avsWrite <= 1'b0;
      avsRead <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hf);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, string s);
      bus(1'b0, a, 32'h0, 4'hf);
      check(q, e, s);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic count_tog(output int c);
      logic p;
      c = 0;
      p = traceClk;
      repeat (8) begin
         @(negedge clk);
         if (traceClk !== p) c++;
         p = traceClk;
      end
   endtask
   task automatic reset_dut;
      @(posedge clk);
      resetn <= 1'b0;
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
   endtask
   initial begin
      n_fail = 0;
      checks = 0;
      resetn = 1'b0;
      avsAddress = 8'h00;
      avsRead = 1'b0;
      avsWrite = 1'b0;
      avsWritedata = 32'h0;
      avsByteenable = 4'h0;
      reset_dut();
      rd(8'h00, 32'h38, "reset word");
      settle(0);
      check(outs, 32'h20, "reset ports");
      wr(8'h00, 32'h30);
      rd(8'h10, 32'h00, "open status");
      wr(8'h00, 32'hffffffff);
      rd(8'h00, 32'hbd, "all ones");
      settle(2);
      check(outs, 32'h78, "fields on");
      count_tog(i);
      check(i, 8, "trace edges");
      wr(8'h00, 32'h30);
      settle(3);
      check(outs, 32'h00, "fields off");
      count_tog(i);
      check(i, 0, "trace idle edges");
      check({31'h0, traceClk}, 32'h0, "trace idle level");
      wr(8'h08, 32'h81);
      rd(8'h00, 32'hb1, "set");
      wr(8'h04, 32'h80);
      wr(8'h0c, 32'h09);
      rd(8'h00, 32'h38, "clear invert");
      bus(1'b1, 8'h00, 32'hff, 4'he);
      rd(8'h00, 32'h38, "lane off");
      wr(8'h20, 32'hff);
      rd(8'h20, 32'h00, "unmapped");
      wr(8'h10, 32'hff);
      rd(8'h10, 32'h00, "status write");
      for (i = 2; i >= 0; i--) begin
         reset_dut();
         wr(8'h00, {26'h0, i[1:0], 4'h8});
         wr(8'h00, 32'h38);
         rd(8'h00, {26'h0, i[1:0], 4'h8}, "locked");
         rd(8'h10, {28'h0, i == 0, i == 1, i == 0, 1'b1}, "st");
         settle(0);
         check(outs, {25'h0, 4'h4, i == 0, i == 1, i == 0}, "m");
      end
      test_done();
   end
endmodule

// *** rtl/cfg_ctrl_if.sv ***
// carriers between the control top and its helper modules
`timescale 1ns/1ns
interface ecc_lock_if;
   logic                  wrEn;
   cfg_ctrl_pkg::ecc_mode_t wrMode;
   cfg_ctrl_pkg::ecc_mode_t mode;
   logic                  locked;
   modport ctrl (output wrEn, output wrMode, input mode, input locked);
   modport lock (input wrEn, input wrMode, output mode, output locked);
endinterface

interface trace_clk_if;
   logic enable;
   logic traceClk;
   logic running;
   modport ctrl (output enable, input traceClk, input running);
   modport gen  (input enable, output traceClk, output running);
endinterface

// *** rtl/cfg_ctrl_pkg.sv ***
// constants and types shared by the configuration control block
package cfg_ctrl_pkg;
   // bus geometry
   localparam int unsigned ADDR_W    = 8;
   localparam int unsigned DATA_W    = 32;
   localparam int unsigned BE_W      = DATA_W / 8;

   // byte addresses of the register words
   localparam logic [7:0] OFS_CONFIG = 8'h00;
   localparam logic [7:0] OFS_CLR    = 8'h04;
   localparam logic [7:0] OFS_SET    = 8'h08;
   localparam logic [7:0] OFS_INV    = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;

   // field positions in the configuration word
   localparam int unsigned BIT_CHARGE_PUMP = 7;
   localparam int unsigned BIT_SPARE_HI    = 6;
   localparam int unsigned BIT_ECC_HI      = 5;
   localparam int unsigned BIT_ECC_LO      = 4;
   localparam int unsigned BIT_DEBUG_PORT  = 3;
   localparam int unsigned BIT_TRACE       = 2;
   localparam int unsigned BIT_SPARE_LO    = 1;
   localparam int unsigned BIT_TWO_WIRE    = 0;

   // implemented bits of the low byte
   localparam logic [7:0] CONFIG_MASK = 8'hbd;

   // field positions in the status word
   localparam int unsigned ST_ECC_LOCKED  = 0;
   localparam int unsigned ST_ECC_ON      = 1;
   localparam int unsigned ST_DYN_ECC_ON  = 2;
   localparam int unsigned ST_WORD_BLOCK  = 3;
   localparam int unsigned ST_TRACE_RUN   = 4;

   // values after reset
   localparam logic       RST_CHARGE_PUMP = 1'b0;
   localparam logic       RST_DEBUG_PORT  = 1'b1;
   localparam logic       RST_TRACE       = 1'b0;
   localparam logic       RST_TWO_WIRE    = 1'b0;

   // error-correction modes
   typedef enum logic [1:0] {
      ECC_ON        = 2'h0,
      ECC_DYNAMIC   = 2'h1,
      ECC_OFF_LOCK  = 2'h2,
      ECC_OFF_OPEN  = 2'h3
   } ecc_mode_t;

   localparam ecc_mode_t RST_ECC_MODE = ECC_OFF_OPEN;

   // trace clock: clk cycles per half period
   localparam int unsigned TRACE_HALF_CYCLES = 1;

   // bus handshake states
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK  = 2'b10
   } bus_state_t;
endpackage

// *** rtl/config_control.sv ***
// configuration control register low byte with avalon-mm slave
//
// Overview of operation
// - charge pump enable bit one turns analog charge pump on, zero off
// - ecc mode 11 disables all error correction, field stays writable
// - ecc mode 10 disables all error correction and locks the field
// - ecc mode 01 enables dynamic error correction and locks the field
// - ecc mode 00 enables correction, locks, blocks single-word programming
// - debug port enable bit one enables jtag port, zero disables it
// - trace bit one drives trace outputs and clock, zero stops both
// - two-wire select bit one makes two-wire debug use tdo pin
// - bits 6 and 1 read zero and ignore writes
`timescale 1ns/1ns
module config_control #(
   parameter int unsigned TRACE_HALF = cfg_ctrl_pkg::TRACE_HALF_CYCLES
) (
   input  wire logic                              clk,
   input  wire logic                              resetn,
   input  wire logic [cfg_ctrl_pkg::ADDR_W-1:0]   avsAddress,
   input  wire logic                              avsRead,
   input  wire logic                              avsWrite,
   input  wire logic [cfg_ctrl_pkg::DATA_W-1:0]   avsWritedata,
   input  wire logic [cfg_ctrl_pkg::BE_W-1:0]     avsByteenable,
   output logic [cfg_ctrl_pkg::DATA_W-1:0]        avsReaddata,
   output logic                                   avsWaitrequest,
   output logic                                   chargePumpEn,
   output logic                                   eccEnable,
   output logic                                   dynEccEnable,
   output logic                                   wordProgBlock,
   output logic                                   debugPortEn,
   output logic                                   traceOutEn,
   output logic                                   traceClk,
   output logic                                   twoWireUseTdo
);
   localparam int unsigned DW = cfg_ctrl_pkg::DATA_W;

   ecc_lock_if  eccBus ();
   trace_clk_if trcBus ();

   cfg_ctrl_pkg::bus_state_t state_q;
   logic          waitReq_q;
   logic [DW-1:0] rdData_q;
   logic          pump_q;
   logic          debug_q;
   logic          trace_q;
   logic          twoWire_q;
   logic          eccOn_q;
   logic          dynEcc_q;
   logic          wordBlock_q;
   logic          traceClk_q;

   logic          request;
   logic          commit;
   logic          lowLane;
   logic          hitCfg;
   logic [7:0]    curByte;
   logic [7:0]    newByte;
   logic [7:0]    wrByte;

   // current low byte as software sees it
   always_comb begin
      curByte = 8'h00;
      curByte[cfg_ctrl_pkg::BIT_CHARGE_PUMP] = pump_q;
      curByte[cfg_ctrl_pkg::BIT_ECC_HI:cfg_ctrl_pkg::BIT_ECC_LO] =
         eccBus.mode;
      curByte[cfg_ctrl_pkg::BIT_DEBUG_PORT] = debug_q;
      curByte[cfg_ctrl_pkg::BIT_TRACE]      = trace_q;
      curByte[cfg_ctrl_pkg::BIT_TWO_WIRE]   = twoWire_q;
   end

   assign request = avsRead || avsWrite;
   assign commit  = avsWrite && (state_q == cfg_ctrl_pkg::BUS_ACK);
   assign lowLane = avsByteenable[0];
   assign wrByte  = avsWritedata[7:0];
   assign hitCfg  = (avsAddress == cfg_ctrl_pkg::OFS_CONFIG) ||
                    (avsAddress == cfg_ctrl_pkg::OFS_CLR) ||
                    (avsAddress == cfg_ctrl_pkg::OFS_SET) ||
                    (avsAddress == cfg_ctrl_pkg::OFS_INV);

   // plain, clear, set and invert views of the same word
   always_comb begin
      newByte = curByte;
      case (avsAddress)
         cfg_ctrl_pkg::OFS_CONFIG: begin
            newByte = wrByte;
         end
         cfg_ctrl_pkg::OFS_CLR: begin
            newByte = curByte & ~wrByte;
         end
         cfg_ctrl_pkg::OFS_SET: begin
            newByte = curByte | wrByte;
         end
         cfg_ctrl_pkg::OFS_INV: begin
            newByte = curByte ^ wrByte;
         end
         default: begin
            newByte = curByte;
         end
      endcase
      newByte = newByte & cfg_ctrl_pkg::CONFIG_MASK;
   end

   // one wait state per access, then a single ready cycle
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_q <= cfg_ctrl_pkg::BUS_IDLE;
      end else begin
         case (state_q)
            cfg_ctrl_pkg::BUS_IDLE: begin
               if (request) begin
                  state_q <= cfg_ctrl_pkg::BUS_ACK;
               end
            end
            cfg_ctrl_pkg::BUS_ACK: begin
               state_q <= cfg_ctrl_pkg::BUS_IDLE;
            end
            default: begin
               state_q <= cfg_ctrl_pkg::BUS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         waitReq_q <= 1'b1;
      end else begin
         waitReq_q <= !(request && state_q == cfg_ctrl_pkg::BUS_IDLE);
      end
   end

   // read data prepared during the wait state
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rdData_q <= '0;
      end else if (avsRead && state_q == cfg_ctrl_pkg::BUS_IDLE) begin
         rdData_q <= '0;
         if (hitCfg) begin
            rdData_q[7:0] <= curByte
               & cfg_ctrl_pkg::CONFIG_MASK;
         end else if (avsAddress == cfg_ctrl_pkg::OFS_STATUS) begin
            rdData_q[cfg_ctrl_pkg::ST_ECC_LOCKED] <= eccBus.locked;
            rdData_q[cfg_ctrl_pkg::ST_ECC_ON]     <= eccOn_q;
            rdData_q[cfg_ctrl_pkg::ST_DYN_ECC_ON] <= dynEcc_q;
            rdData_q[cfg_ctrl_pkg::ST_WORD_BLOCK] <= wordBlock_q;
            rdData_q[cfg_ctrl_pkg::ST_TRACE_RUN]  <= trcBus.running;
         end
      end
   end

   // plain control bits
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pump_q    <= cfg_ctrl_pkg::RST_CHARGE_PUMP;
         debug_q   <= cfg_ctrl_pkg::RST_DEBUG_PORT;
         trace_q   <= cfg_ctrl_pkg::RST_TRACE;
         twoWire_q <= cfg_ctrl_pkg::RST_TWO_WIRE;
      end else if (commit && hitCfg && lowLane) begin
         pump_q    <= newByte[cfg_ctrl_pkg::BIT_CHARGE_PUMP];
         debug_q   <= newByte[cfg_ctrl_pkg::BIT_DEBUG_PORT];
         trace_q   <= newByte[cfg_ctrl_pkg::BIT_TRACE];
         twoWire_q <= newByte[cfg_ctrl_pkg::BIT_TWO_WIRE];
      end
   end

   // locking field lives in its own module
   assign eccBus.wrEn   = commit && hitCfg && lowLane;
   assign eccBus.wrMode = cfg_ctrl_pkg::ecc_mode_t'(
      newByte[cfg_ctrl_pkg::BIT_ECC_HI:cfg_ctrl_pkg::BIT_ECC_LO]);

   ecc_mode_lock u_ecc (
      .clk    (clk),
      .resetn (resetn),
      .port   (eccBus)
   );

   // decoded error-correction controls
   always_ff @(posedge clk) begin
      if (!resetn) begin
         eccOn_q     <= 1'b0;
         dynEcc_q    <= 1'b0;
         wordBlock_q <= 1'b0;
      end else begin
         case (eccBus.mode)
            cfg_ctrl_pkg::ECC_ON: begin
               eccOn_q     <= 1'b1;
               dynEcc_q    <= 1'b0;
               wordBlock_q <= 1'b1;
            end
            cfg_ctrl_pkg::ECC_DYNAMIC: begin
               eccOn_q     <= 1'b0;
               dynEcc_q    <= 1'b1;
               wordBlock_q <= 1'b0;
            end
            cfg_ctrl_pkg::ECC_OFF_LOCK: begin
               eccOn_q     <= 1'b0;
               dynEcc_q    <= 1'b0;
               wordBlock_q <= 1'b0;
            end
            default: begin
               eccOn_q     <= 1'b0;
               dynEcc_q    <= 1'b0;
               wordBlock_q <= 1'b0;
            end
         endcase
      end
   end

   // trace clock follows the trace bit
   assign trcBus.enable = trace_q;

   trace_clock_gen #(
      .HALF_CYCLES (TRACE_HALF)
   ) u_trace (
      .clk    (clk),
      .resetn (resetn),
      .port   (trcBus)
   );

   always_ff @(posedge clk) begin
      if (!resetn) begin
         traceClk_q <= 1'b0;
      end else begin
         traceClk_q <= trcBus.traceClk && trace_q;
      end
   end

   assign avsReaddata    = rdData_q;
   assign avsWaitrequest = waitReq_q;
   assign chargePumpEn   = pump_q;
   assign eccEnable      = eccOn_q;
   assign dynEccEnable   = dynEcc_q;
   assign wordProgBlock  = wordBlock_q;
   assign debugPortEn    = debug_q;
   assign traceOutEn     = trace_q;
   assign traceClk       = traceClk_q;
   assign twoWireUseTdo  = twoWire_q;
endmodule

// *** rtl/ecc_mode_lock.sv ***
// self-locking error-correction mode field
`timescale 1ns/1ns
module ecc_mode_lock (
   input wire logic clk,
   input wire logic resetn,
   ecc_lock_if.lock port
);
   cfg_ctrl_pkg::ecc_mode_t mode_q;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         mode_q <= cfg_ctrl_pkg::RST_ECC_MODE;
      end else if (port.wrEn && !port.locked) begin
         mode_q <= port.wrMode;
      end
   end

   assign port.mode   = mode_q;
   // only the open value leaves the field writable
   assign port.locked = (mode_q != cfg_ctrl_pkg::ECC_OFF_OPEN);
endmodule

// *** rtl/trace_clock_gen.sv ***
// trace clock divider, running only while trace is enabled
`timescale 1ns/1ns
module trace_clock_gen #(
   parameter int unsigned HALF_CYCLES = cfg_ctrl_pkg::TRACE_HALF_CYCLES
) (
   input wire logic clk,
   input wire logic resetn,
   trace_clk_if.gen port
);
   localparam int unsigned CNT_W = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(HALF_CYCLES - 1);

   logic [CNT_W-1:0] count_q;
   logic             clk_q;

   always_ff @(posedge clk) begin
      if (!resetn || !port.enable) begin
         count_q <= '0;
         clk_q   <= 1'b0;
      end else if (count_q == CNT_LAST) begin
         count_q <= '0;
         clk_q   <= ~clk_q;
      end else begin
         count_q <= count_q + 1'b1;
      end
   end

   assign port.traceClk = clk_q;
   assign port.running  = port.enable;
endmodule
